// >>> hdl/imubit_pkg.sv
/*
 imubit_pkg: register map, field layout, reset values and timing for the
 health word and configuration block.
 assumes: one 200 MHz clock; registers are word aligned byte addresses.
*/
package imubit_pkg;
	// clock and packet pacing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned BASE_PERIOD_NS = 10000000; // 100 Hz period
	localparam int unsigned BASE_TICK_CYC = BASE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned BASE_W = 22;
	localparam int unsigned MULT_W = 6;
	// register byte addresses
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_ORIENT = 8'h04;
	localparam logic [7:0] ADDR_FILT = 8'h08;
	localparam logic [7:0] ADDR_ALERT_EN = 8'h0C;
	localparam logic [7:0] ADDR_HEALTH = 8'h10;
	localparam logic [7:0] ADDR_CMD = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
	// baud codes
	localparam logic [1:0] BAUD_9600 = 2'h0;
	localparam logic [1:0] BAUD_19200 = 2'h1;
	localparam logic [1:0] BAUD_38400 = 2'h2;
	localparam logic [1:0] BAUD_57600 = 2'h3;
	// packet types
	localparam logic [1:0] PKT_DEFAULT = 2'h0;
	localparam logic [1:0] PKT_SCALED = 2'h1;
	localparam logic [1:0] PKT_DELTA = 2'h2;
	localparam logic [1:0] PKT_DIAG = 2'h3;
	// packet rate codes: 100,50,25,20,10,5,2 Hz, quiet
	localparam logic [2:0] RATE_100HZ = 3'h0;
	localparam logic [2:0] RATE_QUIET = 3'h7;
	// low-pass corner codes: 5,10,20,50 Hz
	localparam logic [1:0] LPF_20HZ = 2'h2;
	// cfg fields
	localparam int unsigned CFG_BAUD_LSB = 0;
	localparam int unsigned CFG_TYPE_LSB = 2;
	localparam int unsigned CFG_RATE_LSB = 4;
	localparam int unsigned FILT_ACC_LSB = 2;
	localparam logic [4:0] ORIENT_MAX = 5'h17; // 24 mappings
	// alert enable bits: hw, link, sw, sensor
	localparam logic [3:0] ALERT_EN_RST = 4'h8;
	// health word bit positions
	localparam int unsigned HB_FATAL = 0;
	localparam int unsigned HB_HW = 1;
	localparam int unsigned HB_LINK = 2;
	localparam int unsigned HB_SW = 3;
	localparam int unsigned HB_SUMMARY = 8;
	localparam int unsigned HB_HW_AL = 9;
	localparam int unsigned HB_OVR = 12;
	// interrupt bits
	localparam int unsigned IRQ_PKT = 0;
	localparam int unsigned IRQ_OVR = 1;
	localparam int unsigned IRQ_FATAL = 2;
	localparam int unsigned IRQ_FAULT = 3;
	// rate sensor over-range magnitude limit
	localparam logic [15:0] OVR_LIMIT = 16'h7F00;
endpackage : imubit_pkg

// >>> hdl/imubit_pace.sv
/*
 imubit_pace: packet rate divider, one-cycle tick at the chosen rate.
 assumes: rate code from registers on the same clock; quiet gives no tick.
*/
`timescale 1ns/1ps
module imubit_pace
	import imubit_pkg::*;
#(
	parameter int unsigned BASE_CYC = BASE_TICK_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [2:0] rate_i,
	output logic tick_o
);
	logic [BASE_W-1:0] base_r, base_nxt; // 10 ms base count
	logic [MULT_W-1:0] mult_r, mult_nxt; // base periods per packet
	logic [2:0] rate_r; // last rate, to restart on change
	logic tick_nxt;

	// base periods per packet for each rate code
	function automatic logic [MULT_W-1:0] rate_div(input logic [2:0] c);
		case (c)
			3'h0: rate_div = 6'h01;
			3'h1: rate_div = 6'h02;
			3'h2: rate_div = 6'h04;
			3'h3: rate_div = 6'h05;
			3'h4: rate_div = 6'h0A;
			3'h5: rate_div = 6'h14;
			3'h6: rate_div = 6'h32;
			default: rate_div = 6'h00;
		endcase
	endfunction : rate_div

	////////////////////////////////////////////////////////////////
	// next state: a rate change restarts the period cleanly
	always_comb begin
		base_nxt = base_r + 1'b1;
		mult_nxt = mult_r;
		tick_nxt = 1'b0;
		if (rate_i == RATE_QUIET || rate_i != rate_r) begin
			base_nxt = '0;
			mult_nxt = '0;
		end else if (base_r == BASE_W'(BASE_CYC - 1)) begin
			base_nxt = '0;
			mult_nxt = mult_r + 1'b1;
			if (mult_r == rate_div(rate_i) - 1'b1) begin
				mult_nxt = '0;
				tick_nxt = 1'b1;
			end
		end
	end

	// registers only
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			base_r <= '0;
			mult_r <= '0;
			rate_r <= RATE_100HZ;
			tick_o <= 1'b0;
		end else begin
			base_r <= base_nxt;
			mult_r <= mult_nxt;
			rate_r <= rate_i;
			tick_o <= tick_nxt;
		end
	end
endmodule : imubit_pace

// >>> hdl/imubit_core.sv
/*
 imubit_core: configuration registers, packet launch and built-in-test
 health word of a six-axis inertial module.
 assumes: fault inputs and rate samples come from logic on core_clk_i;
 a packet formatter takes pkt_stb_o with type, health and deltas.
*/
// Operation
// - delta packet returns wrapping sums since last
// - baud selectable 9600..57600, default 38400
// - continuous mode emits configured type at rate; a tick meeting get-packet sends only the get-packet type
// - quiet sends packets only on get-packet
// - orientation selects one of 24 mappings
// - separate rate and accel corners, default 20Hz
// - every packet carries the health word
// - get-packet diagnostic returns full status
// - low byte errors, high byte alerts
// - bit 0 fatal, sticky once set
// - bits 1-3 hw, link, sw faults
// - bit 8 set when any enabled alert
// - alerts enableable, default sensor only
// - bit 12 over-range, 13-15 reserved
// - over-range uses rate sensors only
// - rates 100,50,25,20,10,5,2 Hz
// - scaled packet type in engineering units
`timescale 1ns/1ps
module imubit_core
	import imubit_pkg::*;
#(
	parameter int unsigned BASE_CYC = BASE_TICK_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_stb_i,
	input wire logic rd_stb_i,
	output logic [31:0] rd_data_o,
	input wire logic fatal_i,
	input wire logic hw_fault_i,
	input wire logic link_fault_i,
	input wire logic sw_fault_i,
	input wire logic rate_vld_i,
	input wire logic [15:0] rate_x_i,
	input wire logic [15:0] rate_y_i,
	input wire logic [15:0] rate_z_i,
	output logic [1:0] baud_sel_o,
	output logic [4:0] orient_o,
	output logic [1:0] rate_lpf_o,
	output logic [1:0] accel_lpf_o,
	output logic pkt_stb_o,
	output logic [1:0] pkt_type_o,
	output logic [15:0] pkt_health_o,
	output logic [31:0] delta_x_o,
	output logic [31:0] delta_y_o,
	output logic [31:0] delta_z_o,
	output logic irq_o
);
	logic [6:0] cfg_r, cfg_nxt; // baud, type, rate
	logic [4:0] orient_r, orient_nxt;
	logic [3:0] filt_r, filt_nxt; // accel corner high, rate low
	logic [3:0] alert_en_r, alert_en_nxt;
	logic [3:0] irq_stat_r, irq_stat_nxt;
	logic [3:0] irq_mask_r, irq_mask_nxt;
	logic [31:0] rd_nxt;
	logic fatal_r, fatal_nxt; // sticky fatal
	logic ovr_r, ovr_nxt; // latest rate sample over range
	logic fault_r; // any fault last cycle
	logic [15:0] health; // live health word
	logic tick; // continuous-mode packet tick
	logic gp_req; // get-packet command
	logic emit; // a packet leaves this cycle
	logic [1:0] emit_type;
	logic [2:0] ovr_ax; // per-axis over-range
	logic [15:0] samp [3];
	logic [31:0] acc_r [3]; // wrapping delta sums
	logic [31:0] acc_nxt [3];
	logic [31:0] snap_nxt [3];
	logic [31:0] snap_r [3];
	logic [3:0] ev;

	// true when a signed rate sample exceeds the limit in magnitude
	function automatic logic over_lim(input logic [15:0] s);
		logic [15:0] mag;
		mag = s[15] ? (~s + 16'h0001) : s;
		over_lim = mag > OVR_LIMIT;
	endfunction : over_lim

	assign samp[0] = rate_x_i;
	assign samp[1] = rate_y_i;
	assign samp[2] = rate_z_i;

	////////////////////////////////////////////////////////////////
	// packet pacing
	// seven rates from the divider
	imubit_pace #(
		.BASE_CYC(BASE_CYC)
	) u_pace (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.rate_i(cfg_r[CFG_RATE_LSB+:3]),
		.tick_o(tick)
	);

	assign gp_req = wr_stb_i && addr_i == ADDR_CMD;
	// quiet leaves only get-packet
	// a tick already in flight when quiet is written is dropped here,
	// so the switch to polled mode never leaks one stale packet
	assign emit = gp_req | (tick && cfg_r[CFG_RATE_LSB+:3] != RATE_QUIET);
	assign emit_type = gp_req ? wr_data_i[1:0] : cfg_r[CFG_TYPE_LSB+:2];

	////////////////////////////////////////////////////////////////
	// over-range and delta sums, one lane per rate axis
	// only rate samples feed over-range
	generate
		for (genvar a = 0; a < 3; a++) begin : g_axis
			assign ovr_ax[a] = over_lim(samp[a]);
			// sums wrap, restart on delta packet
			always_comb begin
				acc_nxt[a] = acc_r[a];
				snap_nxt[a] = snap_r[a];
				if (rate_vld_i)
					acc_nxt[a] = acc_r[a] + {{16{samp[a][15]}}, samp[a]};
				if (emit && emit_type == PKT_DELTA) begin
					snap_nxt[a] = acc_nxt[a];
					acc_nxt[a] = '0;
				end
			end
			always_ff @(posedge core_clk_i) begin
				if (rst_i) begin
					acc_r[a] <= '0;
					snap_r[a] <= '0;
				end else begin
					acc_r[a] <= acc_nxt[a];
					snap_r[a] <= snap_nxt[a];
				end
			end
		end
	endgenerate

	assign delta_x_o = snap_r[0];
	assign delta_y_o = snap_r[1];
	assign delta_z_o = snap_r[2];

	////////////////////////////////////////////////////////////////
	// health word
	always_comb begin
		health = '0; // reserved bits stay zero
		health[HB_FATAL] = fatal_r;
		health[HB_HW] = hw_fault_i;
		health[HB_LINK] = link_fault_i;
		health[HB_SW] = sw_fault_i;
		health[HB_HW_AL+:3] = alert_en_r[2:0] & {sw_fault_i, link_fault_i, hw_fault_i};
		health[HB_OVR] = alert_en_r[3] & ovr_r;
		health[HB_SUMMARY] = |health[HB_OVR:HB_HW_AL];
	end

	////////////////////////////////////////////////////////////////
	// configuration, status and interrupt next values
	always_comb begin
		cfg_nxt = cfg_r;
		orient_nxt = orient_r;
		filt_nxt = filt_r;
		alert_en_nxt = alert_en_r;
		irq_mask_nxt = irq_mask_r;
		fatal_nxt = fatal_r | fatal_i;
		ovr_nxt = rate_vld_i ? |ovr_ax : ovr_r;
		if (wr_stb_i) begin
			case (addr_i)
				ADDR_CFG: cfg_nxt = wr_data_i[6:0];
				ADDR_ORIENT: begin
					if (wr_data_i[4:0] <= ORIENT_MAX)
						orient_nxt = wr_data_i[4:0];
				end
				ADDR_FILT: filt_nxt = wr_data_i[3:0];
				ADDR_ALERT_EN: alert_en_nxt = wr_data_i[3:0];
				ADDR_IRQ_MASK: irq_mask_nxt = wr_data_i[3:0];
				default: ;
			endcase
		end
		ev = '0;
		ev[IRQ_PKT] = emit;
		ev[IRQ_OVR] = ovr_nxt & ~ovr_r;
		ev[IRQ_FATAL] = fatal_nxt & ~fatal_r;
		ev[IRQ_FAULT] = (hw_fault_i | link_fault_i | sw_fault_i) & ~fault_r;
		// write-one clears, a new event wins the same cycle
		irq_stat_nxt = irq_stat_r;
		if (wr_stb_i && addr_i == ADDR_IRQ_STAT)
			irq_stat_nxt = irq_stat_r & ~wr_data_i[3:0];
		irq_stat_nxt = irq_stat_nxt | ev;
		// read data, unmapped reads zero
		rd_nxt = '0;
		if (rd_stb_i) begin
			case (addr_i)
				ADDR_CFG: rd_nxt[6:0] = cfg_r;
				ADDR_ORIENT: rd_nxt[4:0] = orient_r;
				ADDR_FILT: rd_nxt[3:0] = filt_r;
				ADDR_ALERT_EN: rd_nxt[3:0] = alert_en_r;
				ADDR_HEALTH: rd_nxt[15:0] = health;
				ADDR_IRQ_STAT: rd_nxt[3:0] = irq_stat_r;
				ADDR_IRQ_MASK: rd_nxt[3:0] = irq_mask_r;
				default: rd_nxt = '0;
			endcase
		end
	end

	// registers only
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cfg_r <= {RATE_100HZ, PKT_DEFAULT, BAUD_38400};
			orient_r <= '0;
			filt_r <= {LPF_20HZ, LPF_20HZ};
			alert_en_r <= ALERT_EN_RST;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			fatal_r <= 1'b0;
			ovr_r <= 1'b0;
			fault_r <= 1'b0;
			rd_data_o <= '0;
			pkt_stb_o <= 1'b0;
			pkt_type_o <= PKT_DEFAULT;
			pkt_health_o <= '0;
		end else begin
			cfg_r <= cfg_nxt;
			orient_r <= orient_nxt;
			filt_r <= filt_nxt;
			alert_en_r <= alert_en_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			fatal_r <= fatal_nxt;
			ovr_r <= ovr_nxt;
			fault_r <= hw_fault_i | link_fault_i | sw_fault_i;
			rd_data_o <= rd_nxt;
			pkt_stb_o <= emit;
			if (emit) begin
				pkt_type_o <= emit_type;
				pkt_health_o <= health;
			end
		end
	end

	assign baud_sel_o = cfg_r[CFG_BAUD_LSB+:2];
	assign orient_o = orient_r;
	assign rate_lpf_o = filt_r[1:0];
	assign accel_lpf_o = filt_r[FILT_ACC_LSB+:2];
	// level interrupt, high while an unmasked status bit stands
	assign irq_o = |(irq_stat_r & irq_mask_r);

	////////////////////////////////////////////////////////////////
	// assertions
	property p_delta_snap;
		@(posedge core_clk_i) disable iff (rst_i)
		(emit && emit_type == PKT_DELTA && !rate_vld_i) |=> delta_x_o == $past(acc_r[0]) && acc_r[0] == '0;
	endproperty
	a_delta_snap: assert property (p_delta_snap) else $error("delta snapshot wrong");
	property p_baud_rst;
		@(posedge core_clk_i) $fell(rst_i) |-> baud_sel_o == BAUD_38400 && pkt_type_o == PKT_DEFAULT;
	endproperty
	a_baud_rst: assert property (p_baud_rst) else $error("baud reset wrong");
	property p_cont_emit;
		@(posedge core_clk_i) disable iff (rst_i)
		(tick && !gp_req && cfg_r[CFG_RATE_LSB+:3] != RATE_QUIET) |=>
			pkt_stb_o && pkt_type_o == $past(cfg_r[CFG_TYPE_LSB+:2]);
	endproperty
	a_cont_emit: assert property (p_cont_emit) else $error("tick lost");
	property p_quiet;
		@(posedge core_clk_i) disable iff (rst_i)
		(cfg_r[CFG_RATE_LSB+:3] == RATE_QUIET && !gp_req) |=> !pkt_stb_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("packet in quiet");
	property p_orient;
		@(posedge core_clk_i) disable iff (rst_i) orient_o <= ORIENT_MAX;
	endproperty
	a_orient: assert property (p_orient) else $error("orient out of range");
	property p_filt_rst;
		@(posedge core_clk_i) $fell(rst_i) |-> rate_lpf_o == LPF_20HZ && accel_lpf_o == LPF_20HZ;
	endproperty
	a_filt_rst: assert property (p_filt_rst) else $error("filter reset wrong");
	property p_pkt_health;
		@(posedge core_clk_i) disable iff (rst_i) emit |=> pkt_health_o == $past(health);
	endproperty
	a_pkt_health: assert property (p_pkt_health) else $error("health not captured");
	property p_fatal;
		@(posedge core_clk_i) disable iff (rst_i) fatal_i |=> health[HB_FATAL] [*4];
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal not sticky");
	property p_summary;
		@(posedge core_clk_i) disable iff (rst_i)
		health[HB_SUMMARY] == (|(alert_en_r & {ovr_r, sw_fault_i, link_fault_i, hw_fault_i}));
	endproperty
	a_summary: assert property (p_summary) else $error("summary wrong");
	property p_alert_rst;
		@(posedge core_clk_i) $fell(rst_i) |-> alert_en_r == ALERT_EN_RST;
	endproperty
	a_alert_rst: assert property (p_alert_rst) else $error("alert enables wrong");
	property p_reserved;
		@(posedge core_clk_i) disable iff (rst_i) pkt_health_o[7:4] == '0 && pkt_health_o[15:13] == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_ovr;
		@(posedge core_clk_i) disable iff (rst_i)
		(rate_vld_i && |ovr_ax && alert_en_r[3]) |=> health[HB_OVR];
	endproperty
	a_ovr: assert property (p_ovr) else $error("over-range missed");
	property p_ovr_nom;
		@(posedge core_clk_i) disable iff (rst_i)
		(rate_vld_i && ovr_ax == '0) |=> !health[HB_OVR];
	endproperty
	a_ovr_nom: assert property (p_ovr_nom) else $error("over-range stuck");
	property p_fault_bits;
		@(posedge core_clk_i) disable iff (rst_i)
		emit |=> pkt_health_o[HB_SW:HB_HW] == $past({sw_fault_i, link_fault_i, hw_fault_i});
	endproperty
	a_fault_bits: assert property (p_fault_bits) else $error("fault bits wrong");
	property p_diag;
		@(posedge core_clk_i) disable iff (rst_i)
		(gp_req && wr_data_i[1:0] == PKT_DIAG) |=> pkt_stb_o && pkt_type_o == PKT_DIAG;
	endproperty
	a_diag: assert property (p_diag) else $error("diagnostic packet lost");
	property p_rd_idle;
		@(posedge core_clk_i) disable iff (rst_i)
		!rd_stb_i |=> rd_data_o == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	property p_irq_set;
		@(posedge core_clk_i) disable iff (rst_i)
		ev != '0 |=> (irq_stat_r & $past(ev)) == $past(ev);
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("event lost to clear");
	property p_fatal_irq;
		@(posedge core_clk_i) disable iff (rst_i)
		(fatal_i && !fatal_r) |=> irq_stat_r[IRQ_FATAL];
	endproperty
	a_fatal_irq: assert property (p_fatal_irq) else $error("fatal event not flagged");
	// covers for the main scenarios
	c_gp_diag: cover property (@(posedge core_clk_i) gp_req && wr_data_i[1:0] == PKT_DIAG);
	c_quiet_gp: cover property (@(posedge core_clk_i) cfg_r[CFG_RATE_LSB+:3] == RATE_QUIET && gp_req);
	c_ovr_alert: cover property (@(posedge core_clk_i) health[HB_OVR]);
	c_delta: cover property (@(posedge core_clk_i) emit && emit_type == PKT_DELTA);
	c_irq: cover property (@(posedge core_clk_i) irq_o);
endmodule : imubit_core

// >>> verif/imubit_host_model.sv
/*
 imubit_host_model: packet receiver sitting where the host link would be.
 assumes: packets arrive as one-cycle strobes with type and health beside them.
*/
`timescale 1ns/1ps
module imubit_host_model
	import imubit_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic pkt_stb_i,
	input wire logic [1:0] pkt_type_i,
	input wire logic [15:0] pkt_health_i,
	output logic [15:0] pkt_cnt_o,
	output logic [1:0] last_type_o,
	output logic [15:0] last_health_o
);
	////////////////////////////////////////////////////////////////////////
	// health rides packet
	// the receiver never stalls; the link has no back-pressure
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pkt_cnt_o <= 16'h0000;
			last_type_o <= 2'h0;
			last_health_o <= 16'h0000;
		end else if (pkt_stb_i === 1'b1) begin
			pkt_cnt_o <= pkt_cnt_o + 16'h0001;
			last_type_o <= pkt_type_i;
			last_health_o <= pkt_health_i;
		end
	end
endmodule : imubit_host_model

// >>> verif/imubit_core_tb.sv
/*
 imubit_core_tb: self-checking bench for the configuration and health block.
 assumes: short base period parameter; host model counts packets.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module imubit_core_tb;
	import imubit_pkg::*;
	localparam int unsigned BC = 20; // short base period keeps the run brief
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_r = 8'h00;
	logic [31:0] wd_r = 32'h0;
	logic wr_r = 1'b0, rd_r = 1'b0, fat_r = 1'b0, hw_r = 1'b0, lk_r = 1'b0, sw_r = 1'b0, vld_r = 1'b0;
	logic [15:0] rx_r = 16'h0, ry_r = 16'h0, rz_r = 16'h0, cnt, h, hl, eh;
	logic [31:0] rdat, dx, dy, dz, seed, sx, sy, sz, q;
	logic [1:0] baud, rlpf, alpf, ptype, lt;
	logic [4:0] orient;
	logic pstb, irq, f, ov;
	int n_mismatch = 0;
	int tests_run = 0;
	int divs[7] = '{1, 2, 4, 5, 10, 20, 50}; // dividers of 100 Hz per rate code

	imubit_core #(.BASE_CYC(BC)) i_imubit_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_r),
		.wr_data_i(wd_r), .wr_stb_i(wr_r), .rd_stb_i(rd_r), .rd_data_o(rdat), .fatal_i(fat_r), .hw_fault_i(hw_r),
		.link_fault_i(lk_r), .sw_fault_i(sw_r), .rate_vld_i(vld_r), .rate_x_i(rx_r), .rate_y_i(ry_r),
		.rate_z_i(rz_r), .baud_sel_o(baud), .orient_o(orient), .rate_lpf_o(rlpf), .accel_lpf_o(alpf),
		.pkt_stb_o(pstb), .pkt_type_o(ptype), .pkt_health_o(h), .delta_x_o(dx), .delta_y_o(dy),
		.delta_z_o(dz), .irq_o(irq));
	imubit_host_model i_imubit_host_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .pkt_stb_i(pstb),
		.pkt_type_i(ptype), .pkt_health_i(h), .pkt_cnt_o(cnt), .last_type_o(lt), .last_health_o(hl));

	////////////////////////////////////////////////////////////////////////
	// clock and watchdog; the full sequence needs about 6700 cycles
	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (40000) @(posedge core_clk_i);
		n_mismatch++;
		wrap_up();
	end

	// galois lfsr, fixed start keeps runs repeatable
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction : lfsr
	// over-range means magnitude strictly above the limit
	function automatic logic over(input logic [15:0] x);
		return (x[15] ? (16'h0000 - x) : x) > OVR_LIMIT;
	endfunction : over
	function automatic logic [15:0] exp_h(input logic fl, input logic [2:0] flt, input logic o, input logic [3:0] en);
		logic [15:0] w;
		w = 16'h0000; // reserved bits stay low
		w[HB_FATAL] = fl;
		w[3:1] = flt;
		w[11:9] = flt & en[2:0];
		w[HB_OVR] = o & en[3];
		w[HB_SUMMARY] = |w[12:9];
		return w;
	endfunction : exp_h

	////////////////////////////////////////////////////////////////////////
	// bus tasks: strobes last one cycle, read data sampled the cycle after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr_r <= a;
		wd_r <= d;
		wr_r <= 1'b1;
		@(posedge core_clk_i);
		wr_r <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		addr_r <= a;
		rd_r <= 1'b1;
		@(posedge core_clk_i);
		rd_r <= 1'b0;
		#1 d = rdat;
	endtask : rd
	task automatic cmd(input logic [1:0] t);
		wr(ADDR_CMD, {30'h0, t});
		#1;
		`CHK(pstb, 1'b1)
		`CHK(ptype, t)
	endtask : cmd
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(posedge core_clk_i);
		rx_r <= x;
		ry_r <= y;
		rz_r <= z;
		vld_r <= 1'b1;
		@(posedge core_clk_i);
		vld_r <= 1'b0;
	endtask : smp
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'h9ae8;
		f = 1'b0;
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(ADDR_CFG, q);
		`CHK(q, 32'h02)
		rd(ADDR_FILT, q);
		`CHK(q, 32'h0A)
		rd(ADDR_ALERT_EN, q);
		`CHK(q, 32'h08)
		`CHK({rlpf, alpf}, {LPF_20HZ, LPF_20HZ})
		rd(8'h20, q);
		`CHK(q, 32'h0)
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_CFG, {25'h0, RATE_QUIET, 2'h0, b[1:0]});
			@(posedge core_clk_i);
			`CHK(baud, b[1:0])
		end
		q = {16'h0, cnt};
		repeat (4 * BC) @(posedge core_clk_i);
		`CHK(cnt, q[15:0])
		// last mapping kept, out of range ignored
		wr(ADDR_ORIENT, 32'h17);
		wr(ADDR_ORIENT, 32'h18);
		@(posedge core_clk_i);
		`CHK(orient, ORIENT_MAX)
		wr(ADDR_FILT, 32'h7);
		@(posedge core_clk_i);
		`CHK({rlpf, alpf}, 4'hD)
		for (int t = 0; t < 4; t++) cmd(t[1:0]);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			if (i == 7) seed = 32'h80FF007F;
			wr(ADDR_ALERT_EN, {28'h0, seed[3:0]});
			@(posedge core_clk_i);
			{sw_r, lk_r, hw_r} <= seed[6:4];
			fat_r <= (i == 5);
			smp(seed[31:16], 16'h0100, 16'h0100);
			fat_r <= 1'b0;
			f = f | (i == 5);
			ov = over(seed[31:16]);
			eh = exp_h(f, seed[6:4], ov, seed[3:0]);
			cmd(PKT_DEFAULT);
			`CHK(h, eh)
			// the host takes the packet one edge after the strobe
			@(posedge core_clk_i);
			#1;
			`CHK(hl, eh)
			rd(ADDR_HEALTH, q);
			`CHK(q, {16'h0, eh})
		end
		cmd(PKT_DELTA);
		{sx, sy, sz} = '0;
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			smp({4'h0, seed[11:0]}, {4'h0, seed[23:12]}, {8'h0, seed[31:24]});
			sx += seed[11:0];
			sy += seed[23:12];
			sz += seed[31:24];
		end
		cmd(PKT_DELTA);
		`CHK({dx, dy, dz}, {sx, sy, sz})
		cmd(PKT_DELTA);
		`CHK({dx, dy, dz}, 96'h0)
		// each rate emits scaled packets at its pace
		for (int r = 0; r < 7; r++) begin
			wr(ADDR_CFG, {25'h0, r[2:0], PKT_SCALED, BAUD_38400});
			q = {16'h0, cnt};
			repeat (BC * divs[r] * 7 / 2) @(posedge core_clk_i);
			`CHK(cnt - q[15:0], 16'h3)
			`CHK(lt, PKT_SCALED)
		end
		// interrupt: raise, mask, clear
		wr(ADDR_CFG, {25'h0, RATE_QUIET, 4'h2});
		{sw_r, lk_r, hw_r} <= 3'h0;
		wr(ADDR_IRQ_STAT, 32'hF);
		wr(ADDR_IRQ_MASK, 32'h1);
		cmd(PKT_DEFAULT);
		@(posedge core_clk_i);
		`CHK(irq, 1'b1)
		rd(ADDR_IRQ_STAT, q);
		`CHK(q[IRQ_PKT], 1'b1)
		wr(ADDR_IRQ_MASK, 32'h0);
		@(posedge core_clk_i);
		`CHK(irq, 1'b0)
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_IRQ_STAT, 32'hF);
		@(posedge core_clk_i);
		`CHK(irq, 1'b0)
		wrap_up();
	end
endmodule : imubit_core_tb
